// ---- core/rpr_pkg.sv ----
// ============================================================
// Register map and field layout of the charger control slice
package rpr_pkg;

    // ============================================================
    // Register offsets
    localparam logic [7:0] OFF_CTRL_FIVE    = 8'h14;
    localparam logic [7:0] OFF_RESERVED     = 8'h15;
    localparam logic [7:0] OFF_THERMAL      = 8'h16;

    // ============================================================
    // Reset values of whole registers
    localparam logic [7:0] RST_CTRL_FIVE    = 8'h16;
    localparam logic [7:0] RST_RESERVED     = 8'h00;
    localparam logic [7:0] RST_THERMAL      = 8'hC0;

    // ============================================================
    // Field positions in the fifth control register
    localparam int         POS_FITTED       = 7;
    localparam int         POS_CTRL5_RSVD   = 6;
    localparam int         POS_SENSE        = 5;
    localparam int         POS_LIMIT_LO     = 3;
    localparam int         POS_INT_LIMIT    = 2;
    localparam int         POS_EXT_LIMIT    = 1;
    localparam int         POS_DISCH_OC     = 0;

    // ============================================================
    // Field positions in the temperature control register
    localparam int         POS_TREG_LO      = 6;
    localparam int         POS_TSHUT_LO     = 4;
    localparam int         POS_BUS_PD       = 3;
    localparam int         POS_SRC1_PD      = 2;
    localparam int         POS_SRC2_PD      = 1;
    localparam int         POS_THERM_RSVD   = 0;

    // ============================================================
    // Field reset values
    localparam logic [0:0] RST_FITTED       = 1'h0;
    localparam logic [0:0] RST_SENSE        = 1'h0;
    localparam logic [1:0] RST_LIMIT        = 2'h2;
    localparam logic [0:0] RST_INT_LIMIT    = 1'h1;
    localparam logic [0:0] RST_EXT_LIMIT    = 1'h1;
    localparam logic [0:0] RST_DISCH_OC     = 1'h0;
    localparam logic [1:0] RST_TREG         = 2'h3;
    localparam logic [1:0] RST_TSHUT        = 2'h0;
    localparam logic [0:0] RST_PD           = 1'h0;

    // ============================================================
    // Discharge limit codes in OTG mode
    localparam logic [1:0] LIMIT_3A         = 2'h0;
    localparam logic [1:0] LIMIT_4A         = 2'h1;
    localparam logic [1:0] LIMIT_5A         = 2'h2;
    localparam logic [1:0] LIMIT_OFF        = 2'h3;

endpackage

// ---- core/rpr_field.sv ----
`timescale 1ns/1ps
// ============================================================
// One register field with selectable clear sources and a lock
module rpr_field
    import rpr_pkg::*;
#(
    parameter int         W      = 1,
    parameter logic [W-1:0] RST_VAL = '0,
    parameter bit         WD_CLR = 1'b0,
    parameter bit         RR_CLR = 1'b1
) (
    input  wire logic         core_clk_in,
    input  wire logic         reset_in,
    input  wire logic         wr_en_in,
    input  wire logic [W-1:0] wr_data_in,
    input  wire logic         wd_expire_in,
    input  wire logic         reg_reset_in,
    input  wire logic         hold_zero_in,
    output logic      [W-1:0] value_out
);

    logic [W-1:0] next_value;

    // Default restore beats lock, lock beats a host write
    always_comb begin
        next_value = value_out;
        if ((RR_CLR && reg_reset_in) || (WD_CLR && wd_expire_in)) begin
            next_value = RST_VAL;
        end else if (hold_zero_in) begin
            next_value = '0;
        end else if (wr_en_in) begin
            next_value = wr_data_in;
        end
    end

    // Field storage
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            value_out <= RST_VAL;
        end else begin
            value_out <= next_value;
        end
    end

endmodule // rpr_field

// ---- core/rpr_read_mux.sv ----
`timescale 1ns/1ps
// ============================================================
// Read data selection; unmapped offsets read as zero
module rpr_read_mux
    import rpr_pkg::*;
(
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] ctrl_five_in,
    input  wire logic [7:0] thermal_in,
    output logic      [7:0] rdata_out
);

    // Address decode
    always_comb begin
        unique case (addr_in)
            OFF_CTRL_FIVE: rdata_out = ctrl_five_in;
            OFF_RESERVED:  rdata_out = RST_RESERVED;
            OFF_THERMAL:   rdata_out = thermal_in;
            default:       rdata_out = 8'h00;
        endcase
    end

endmodule // rpr_read_mux

// ---- core/rpr_regs.sv ----
`timescale 1ns/1ps
// ============================================================
// Charger control and thermal register slice
//
// Notes on behaviour
// - Fitted flag low forces discharge overcurrent enable (bit 0) to zero.
// - Fitted flag high lets discharge overcurrent enable be programmed.
// - Fitted flag is bit 7, read/write, resets to 0; host sets it.
// - Bit 5 enables discharge sensing; default 0, cleared by watchdog and reset command.
// - Bits 4-3 pick OTG discharge limit 3A/4A/5A/off; default 5A.
// - Bit 2 enables internal input limit; default 1, restored by watchdog and reset.
// - Bit 1 enables pin input limit; default 1, restored by reset command only.
// - Bit 0 enables discharge overcurrent; default 0, cleared by watchdog and reset.
// - Offset 14h reads 16h after reset; bit 6 reads zero.
// - Offset 15h is reserved and always reads 00h.
// - Offset 16h reads C0h after reset; bit 0 reads zero.
// - Bits 5-4 pick shutdown 150/130/120/85; default 150, watchdog restores.
// - Bit 3 enables bus input pull-down; cleared by reset command only.
// - Bit 2 enables first source pull-down; cleared by reset command only.
// - Bit 1 enables second source pull-down; cleared by reset command only.
module rpr_regs
    import rpr_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       reset_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_wr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_rd_in,
    input  wire logic       wd_expire_in,
    input  wire logic       reg_reset_in,
    output logic      [7:0] reg_rdata_out,
    output logic            ship_switch_fitted_out,
    output logic            discharge_sense_en_out,
    output logic      [1:0] otg_discharge_limit_out,
    output logic            internal_input_limit_en_out,
    output logic            external_input_limit_en_out,
    output logic            discharge_overcurrent_en_out,
    output logic      [1:0] thermal_reg_threshold_out,
    output logic      [1:0] thermal_shutdown_threshold_out,
    output logic            bus_pulldown_en_out,
    output logic            source1_pulldown_en_out,
    output logic            source2_pulldown_en_out
);

    // ============================================================
    // Write decode and ship lock
    logic       wr_ctrl_five;
    logic       wr_thermal;
    logic       next_fitted;
    logic       ship_lock;
    logic [7:0] ctrl_five_view;
    logic [7:0] thermal_view;
    logic [7:0] mux_rdata;
    logic [7:0] next_rdata;

    // Register write strobes
    always_comb begin
        wr_ctrl_five = reg_wr_in && (reg_addr_in == OFF_CTRL_FIVE);
        wr_thermal   = reg_wr_in && (reg_addr_in == OFF_THERMAL);
    end

    // Lock follows the fitted flag value that takes effect this edge
    always_comb begin
        next_fitted = ship_switch_fitted_out;
        if (wr_ctrl_five) begin
            next_fitted = reg_wdata_in[POS_FITTED];
        end
        ship_lock = !next_fitted;
    end

    // ============================================================
    // Fifth control register fields
    rpr_field #(.W(1), .RST_VAL(RST_FITTED), .WD_CLR(1'b0), .RR_CLR(1'b0)) u_fitted (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .wr_en_in     (wr_ctrl_five),
        .wr_data_in   (reg_wdata_in[POS_FITTED]),
        .wd_expire_in (wd_expire_in),
        .reg_reset_in (reg_reset_in),
        .hold_zero_in (1'b0),
        .value_out    (ship_switch_fitted_out)
    );

    rpr_field #(.W(1), .RST_VAL(RST_SENSE), .WD_CLR(1'b1), .RR_CLR(1'b1)) u_sense (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .wr_en_in     (wr_ctrl_five),
        .wr_data_in   (reg_wdata_in[POS_SENSE]),
        .wd_expire_in (wd_expire_in),
        .reg_reset_in (reg_reset_in),
        .hold_zero_in (1'b0),
        .value_out    (discharge_sense_en_out)
    );

    rpr_field #(.W(2), .RST_VAL(RST_LIMIT), .WD_CLR(1'b1), .RR_CLR(1'b1)) u_limit (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .wr_en_in     (wr_ctrl_five),
        .wr_data_in   (reg_wdata_in[POS_LIMIT_LO +: 2]),
        .wd_expire_in (wd_expire_in),
        .reg_reset_in (reg_reset_in),
        .hold_zero_in (1'b0),
        .value_out    (otg_discharge_limit_out)
    );

    rpr_field #(.W(1), .RST_VAL(RST_INT_LIMIT), .WD_CLR(1'b1), .RR_CLR(1'b1)) u_int_lim (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .wr_en_in     (wr_ctrl_five),
        .wr_data_in   (reg_wdata_in[POS_INT_LIMIT]),
        .wd_expire_in (wd_expire_in),
        .reg_reset_in (reg_reset_in),
        .hold_zero_in (1'b0),
        .value_out    (internal_input_limit_en_out)
    );

    // Pin limit survives watchdog expiry
    rpr_field #(.W(1), .RST_VAL(RST_EXT_LIMIT), .WD_CLR(1'b0), .RR_CLR(1'b1)) u_ext_lim (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .wr_en_in     (wr_ctrl_five),
        .wr_data_in   (reg_wdata_in[POS_EXT_LIMIT]),
        .wd_expire_in (wd_expire_in),
        .reg_reset_in (reg_reset_in),
        .hold_zero_in (1'b0),
        .value_out    (external_input_limit_en_out)
    );

    // Locked to zero while no ship switch is fitted
    rpr_field #(.W(1), .RST_VAL(RST_DISCH_OC), .WD_CLR(1'b1), .RR_CLR(1'b1)) u_disch_oc (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .wr_en_in     (wr_ctrl_five),
        .wr_data_in   (reg_wdata_in[POS_DISCH_OC]),
        .wd_expire_in (wd_expire_in),
        .reg_reset_in (reg_reset_in),
        .hold_zero_in (ship_lock),
        .value_out    (discharge_overcurrent_en_out)
    );

    // ============================================================
    // Temperature control register fields
    rpr_field #(.W(2), .RST_VAL(RST_TREG), .WD_CLR(1'b1), .RR_CLR(1'b1)) u_treg (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .wr_en_in     (wr_thermal),
        .wr_data_in   (reg_wdata_in[POS_TREG_LO +: 2]),
        .wd_expire_in (wd_expire_in),
        .reg_reset_in (reg_reset_in),
        .hold_zero_in (1'b0),
        .value_out    (thermal_reg_threshold_out)
    );

    rpr_field #(.W(2), .RST_VAL(RST_TSHUT), .WD_CLR(1'b1), .RR_CLR(1'b1)) u_tshut (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .wr_en_in     (wr_thermal),
        .wr_data_in   (reg_wdata_in[POS_TSHUT_LO +: 2]),
        .wd_expire_in (wd_expire_in),
        .reg_reset_in (reg_reset_in),
        .hold_zero_in (1'b0),
        .value_out    (thermal_shutdown_threshold_out)
    );

    rpr_field #(.W(1), .RST_VAL(RST_PD), .WD_CLR(1'b0), .RR_CLR(1'b1)) u_bus_pd (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .wr_en_in     (wr_thermal),
        .wr_data_in   (reg_wdata_in[POS_BUS_PD]),
        .wd_expire_in (wd_expire_in),
        .reg_reset_in (reg_reset_in),
        .hold_zero_in (1'b0),
        .value_out    (bus_pulldown_en_out)
    );

    rpr_field #(.W(1), .RST_VAL(RST_PD), .WD_CLR(1'b0), .RR_CLR(1'b1)) u_src1_pd (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .wr_en_in     (wr_thermal),
        .wr_data_in   (reg_wdata_in[POS_SRC1_PD]),
        .wd_expire_in (wd_expire_in),
        .reg_reset_in (reg_reset_in),
        .hold_zero_in (1'b0),
        .value_out    (source1_pulldown_en_out)
    );

    rpr_field #(.W(1), .RST_VAL(RST_PD), .WD_CLR(1'b0), .RR_CLR(1'b1)) u_src2_pd (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .wr_en_in     (wr_thermal),
        .wr_data_in   (reg_wdata_in[POS_SRC2_PD]),
        .wd_expire_in (wd_expire_in),
        .reg_reset_in (reg_reset_in),
        .hold_zero_in (1'b0),
        .value_out    (source2_pulldown_en_out)
    );

    // ============================================================
    // Read path
    // Reserved bits are tied low in the read views
    always_comb begin
        ctrl_five_view = {ship_switch_fitted_out, 1'b0,
                          discharge_sense_en_out, otg_discharge_limit_out,
                          internal_input_limit_en_out, external_input_limit_en_out,
                          discharge_overcurrent_en_out};
        thermal_view   = {thermal_reg_threshold_out, thermal_shutdown_threshold_out,
                          bus_pulldown_en_out, source1_pulldown_en_out,
                          source2_pulldown_en_out, 1'b0};
    end

    rpr_read_mux u_rd_mux (
        .addr_in      (reg_addr_in),
        .ctrl_five_in (ctrl_five_view),
        .thermal_in   (thermal_view),
        .rdata_out    (mux_rdata)
    );

    // Read data is captured on a read strobe and held until the next one
    always_comb begin
        next_rdata = reg_rdata_out;
        if (reg_rd_in) begin
            next_rdata = mux_rdata;
        end
    end

    // Read data register
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            reg_rdata_out <= next_rdata;
        end
    end

    // ============================================================
    // Checks
    AST_LOCK_HOLDS: assert property (@(posedge core_clk_in) disable iff (reset_in)
        !ship_switch_fitted_out |-> !discharge_overcurrent_en_out)
        else $error("Overcurrent enable set while no ship switch fitted");

    AST_UNLOCK_WRITE: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (wr_ctrl_five && reg_wdata_in[POS_FITTED] && !wd_expire_in && !reg_reset_in)
        |=> (discharge_overcurrent_en_out == $past(reg_wdata_in[POS_DISCH_OC])))
        else $error("Unlocked overcurrent enable did not take the written value");

    AST_FITTED_KEEPS: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (!wr_ctrl_five && (wd_expire_in || reg_reset_in))
        |=> $stable(ship_switch_fitted_out))
        else $error("Fitted flag changed without a host write");

    AST_SENSE_CLEAR: assert property (@(posedge core_clk_in) disable iff (reset_in)
        wd_expire_in |=> !discharge_sense_en_out ##1 discharge_sense_en_out == $past(
        discharge_sense_en_out) || $past(wr_ctrl_five))
        else $error("Sense enable not cleared or disturbed after watchdog");

    AST_LIMIT_DEFAULT: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (wd_expire_in || reg_reset_in) |=> (otg_discharge_limit_out == LIMIT_5A))
        else $error("Discharge limit not restored to 5A");

    AST_INT_RESTORE: assert property (@(posedge core_clk_in) disable iff (reset_in)
        wd_expire_in |=> internal_input_limit_en_out)
        else $error("Internal limit enable not restored by watchdog");

    AST_EXT_KEEP: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (wd_expire_in && !reg_reset_in && !wr_ctrl_five)
        |=> $stable(external_input_limit_en_out))
        else $error("Pin limit enable disturbed by watchdog");

    AST_OC_CLEAR: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (wd_expire_in || reg_reset_in) |=> !discharge_overcurrent_en_out)
        else $error("Overcurrent enable not cleared");

    AST_READ_CTRL5: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (reg_rd_in && reg_addr_in == OFF_CTRL_FIVE)
        |=> (reg_rdata_out == $past(ctrl_five_view)) && !reg_rdata_out[POS_CTRL5_RSVD])
        else $error("Fifth control register read back wrong");

    AST_READ_RSVD: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (reg_rd_in && reg_addr_in == OFF_RESERVED) |=> (reg_rdata_out == RST_RESERVED))
        else $error("Reserved register did not read zero");

    AST_READ_THERM: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (reg_rd_in && reg_addr_in == OFF_THERMAL)
        |=> !reg_rdata_out[POS_THERM_RSVD]
        && (reg_rdata_out[7:6] == $past(thermal_reg_threshold_out)))
        else $error("Temperature register read back wrong");

    AST_TREG_RESTORE: assert property (@(posedge core_clk_in) disable iff (reset_in)
        wd_expire_in |=> (thermal_reg_threshold_out == RST_TREG))
        else $error("Regulation threshold not restored");

    AST_TSHUT_RESTORE: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (wd_expire_in || reg_reset_in) |=> (thermal_shutdown_threshold_out == RST_TSHUT))
        else $error("Shutdown threshold not restored");

    AST_PD_KEEP: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (wd_expire_in && !reg_reset_in && !wr_thermal)
        |=> $stable({bus_pulldown_en_out, source1_pulldown_en_out, source2_pulldown_en_out}))
        else $error("Pull-down enables disturbed by watchdog");

    AST_PD_CLEAR: assert property (@(posedge core_clk_in) disable iff (reset_in)
        reg_reset_in |=> !bus_pulldown_en_out && !source1_pulldown_en_out
        && !source2_pulldown_en_out)
        else $error("Pull-down enables not cleared by reset command");

    AST_PD_WRITE: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (wr_thermal && !reg_reset_in)
        |=> (source2_pulldown_en_out == $past(reg_wdata_in[POS_SRC2_PD])))
        else $error("Second source pull-down did not take the write");

    AST_LOCKED_WRITE: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (wr_ctrl_five && !reg_wdata_in[POS_FITTED] && reg_wdata_in[POS_DISCH_OC])
        |=> (!discharge_overcurrent_en_out && !ship_switch_fitted_out)
        ##1 (!discharge_overcurrent_en_out || $past(wr_ctrl_five)))
        else $error("Locked overcurrent write was not dropped");

    AST_WD_SELECTIVE: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (wd_expire_in && !reg_reset_in && !wr_ctrl_five && !wr_thermal)
        |=> $stable(bus_pulldown_en_out) && internal_input_limit_en_out
        && (otg_discharge_limit_out == RST_LIMIT))
        else $error("Watchdog restore touched the wrong fields");

endmodule // rpr_regs

// ---- verification/rpr_host_model.sv ----
`timescale 1ns/1ps
// ============================================================
// Host side of the register port: single-byte strobe transfers
module rpr_host_model
    import rpr_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic [7:0] rdata_in,
    output logic      [7:0] addr_out,
    output logic            wr_out,
    output logic      [7:0] wdata_out,
    output logic            rd_out
);
    // Idle port values from time zero
    initial begin
        addr_out  = 8'h00;
        wr_out    = 1'b0;
        wdata_out = 8'h00;
        rd_out    = 1'b0;
    end

    // Write one byte; strobe stands for exactly one sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        #1;
        addr_out  = a;
        wdata_out = d;
        wr_out    = 1'b1;
        @(posedge core_clk_in);
        #1;
        wr_out    = 1'b0;
        wdata_out = ~d; // Stale data scrambled once released
    endtask

    // Read one byte; data is taken once the answering edge has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        #1;
        addr_out = a;
        rd_out   = 1'b1;
        @(posedge core_clk_in);
        #1;
        rd_out   = 1'b0;
        addr_out = ~a;
        d        = rdata_in;
    endtask
endmodule // rpr_host_model

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
// ============================================================
// Self-checking bench of the charger control register slice
module testbench
    import rpr_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       wd  = 1'b0;
    logic       rr  = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic       wr, rd, fit, sns, iel, eel, oc, bpd, s1pd, s2pd;
    logic [1:0] lim, treg, tsh;
    int         n_mismatch = 0;
    int         checks     = 0;
    int         seed       = 91973;
    logic [7:0] d;

    always #2.5 clk = ~clk;

    rpr_host_model u_rpr_host_model (.core_clk_in(clk), .rdata_in(rdata), .addr_out(addr),
        .wr_out(wr), .wdata_out(wdata), .rd_out(rd));

    rpr_regs u_rpr_regs (.core_clk_in(clk), .reset_in(rst), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .wd_expire_in(wd),
        .reg_reset_in(rr), .reg_rdata_out(rdata), .ship_switch_fitted_out(fit),
        .discharge_sense_en_out(sns), .otg_discharge_limit_out(lim),
        .internal_input_limit_en_out(iel), .external_input_limit_en_out(eel),
        .discharge_overcurrent_en_out(oc), .thermal_reg_threshold_out(treg),
        .thermal_shutdown_threshold_out(tsh), .bus_pulldown_en_out(bpd),
        .source1_pulldown_en_out(s1pd), .source2_pulldown_en_out(s2pd));

    // Expected register views after writing d from any state
    function automatic logic [7:0] e14(input logic [7:0] v);
        return {v[7], 1'b0, v[5:1], v[0] & v[7]};
    endfunction
    function automatic logic [7:0] e16(input logic [7:0] v);
        return {v[7:1], 1'b0};
    endfunction

    // Byte comparison
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Read a register and compare, then compare its field outputs
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        u_rpr_host_model.rd(a, v);
        cmp8($sformatf("read %h", a), exp, v);
        if (a == OFF_CTRL_FIVE) cmp8("ports14", exp, {fit, 1'b0, sns, lim, iel, eel, oc});
        if (a == OFF_THERMAL) cmp8("ports16", exp, {treg, tsh, bpd, s1pd, s2pd, 1'b0});
    endtask

    // One-cycle pulse of watchdog expiry or register-reset command
    task automatic pulse(input bit cmd);
        @(posedge clk);
        #1;
        if (cmd) rr = 1'b1; else wd = 1'b1;
        @(posedge clk);
        #1;
        rr = 1'b0;
        wd = 1'b0;
    endtask

    task automatic end_of_test;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        rchk(OFF_CTRL_FIVE, RST_CTRL_FIVE);
        rchk(OFF_RESERVED, RST_RESERVED);
        rchk(OFF_THERMAL, RST_THERMAL);
        rchk(8'h20, 8'h00);
        u_rpr_host_model.wr(OFF_CTRL_FIVE, 8'h81);
        rchk(OFF_CTRL_FIVE, 8'h81);
        u_rpr_host_model.wr(OFF_CTRL_FIVE, 8'h01);
        rchk(OFF_CTRL_FIVE, 8'h00);
        u_rpr_host_model.wr(OFF_RESERVED, 8'hFF);
        rchk(OFF_RESERVED, 8'h00);
        for (int i = 0; i < 24; i++) begin
            d = 8'($random(seed));
            if (i < 4) d = {d[7:5], 2'(i), d[2:0]};
            u_rpr_host_model.wr(OFF_CTRL_FIVE, d);
            rchk(OFF_CTRL_FIVE, e14(d));
            u_rpr_host_model.wr(OFF_THERMAL, d);
            rchk(OFF_THERMAL, e16(d));
        end
        u_rpr_host_model.wr(OFF_CTRL_FIVE, 8'hBD);
        u_rpr_host_model.wr(OFF_THERMAL, 8'h3F);
        pulse(1'b0);
        rchk(OFF_CTRL_FIVE, 8'h94);
        rchk(OFF_THERMAL, 8'hCE);
        u_rpr_host_model.wr(OFF_THERMAL, 8'h0F);
        pulse(1'b1);
        rchk(OFF_CTRL_FIVE, 8'h96);
        rchk(OFF_THERMAL, RST_THERMAL);
        // Power-on reset in mid-run clears the fitted flag as well
        u_rpr_host_model.wr(OFF_THERMAL, 8'hFE);
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        rchk(OFF_CTRL_FIVE, RST_CTRL_FIVE);
        rchk(OFF_THERMAL, RST_THERMAL);
        end_of_test();
    end

    // Watchdog against a hang, far beyond the expected run length
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
endmodule // testbench
